// ---- verilog/vpc_control.sv ----
// vector placement, scan disable and pull-up control register
`timescale 1ns/1ps
`default_nettype none
`include "vpc_map.svh"
module vpc_control #(
    parameter int PORT_PINS = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire vpc_pkg::vpc_bus_req_t avs_req,
    output logic                       avs_waitrequest,
    output logic      [7:0]            avs_readdata,
    input  wire vpc_pkg::vpc_fuse_t    fuses,
    input  wire logic                  exec_in_boot,
    input  wire logic                  instr_done,
    input  wire logic [PORT_PINS-1:0]  pin_direction_bit,
    input  wire logic [PORT_PINS-1:0]  pin_output_bit,
    output logic      [PORT_PINS-1:0]  pullup_enable,
    output logic                       irq_block,
    output logic                       vec_sel,
    output logic      [15:0]           vector_base,
    output logic      [15:0]           reset_address,
    output logic      [15:0]           last_vector_addr,
    output logic                       scan_port_active,
    output logic                       global_pullup_off
);
    vpc_pkg::vpc_state_t st;
    vpc_pkg::vpc_state_t next_st;
    logic [15:0]         boot_base;
    logic                wr_hit;
    logic                rd_hit;
    logic [15:0]         sect_base;

    vpc_boot_base u_base (
        .boot_size_fuse (fuses.boot_size_fuse),
        .boot_base      (boot_base)
    );

    // writes answer at once; reads take one wait state so the data come from a flop
    assign avs_waitrequest = avs_req.read && !st.rd_ack;
    assign wr_hit = avs_req.write && (avs_req.address == `VPC_CTRL_ADDR);
    assign rd_hit = avs_req.read && (avs_req.address == `VPC_CTRL_ADDR);

    always_comb begin
        next_st = st;
        next_st.readdata = 8'h00;
        next_st.rd_ack = avs_req.read && !st.rd_ack;
        if (rd_hit && !st.rd_ack) begin
            next_st.readdata[`VPC_BIT_CHG_EN]     = st.chg_en;
            next_st.readdata[`VPC_BIT_VEC_SEL]    = st.vec_sel;
            next_st.readdata[`VPC_BIT_PULLUP_OFF] = st.pullup_off;
            next_st.readdata[`VPC_BIT_SCAN_DIS]   = st.scan_dis;
        end
        // unlock window timing
        case (st.phase)
            vpc_pkg::VPC_IDLE: begin
            end
            vpc_pkg::VPC_OPEN: begin
                if (st.win_cnt == `VPC_WINDOW_CYC - 3'h1) begin
                    next_st.chg_en = 1'b0;
                    next_st.phase  = vpc_pkg::VPC_IDLE;
                end else begin
                    next_st.win_cnt = st.win_cnt + 3'h1;
                end
            end
            vpc_pkg::VPC_HOLD: begin
                // mask kept until the instruction after the select write retires
                if (instr_done) begin
                    next_st.phase = vpc_pkg::VPC_IDLE;
                end
            end
            default: next_st.phase = vpc_pkg::VPC_IDLE;
        endcase
        // scan disable pending window
        if (st.scan_cnt != 3'h0) begin
            next_st.scan_cnt = st.scan_cnt - 3'h1;
        end
        if (wr_hit) begin
            next_st.pullup_off = avs_req.writedata[`VPC_BIT_PULLUP_OFF];
            if (avs_req.writedata[`VPC_BIT_CHG_EN]) begin
                // restarting the window on a repeated unlock write
                next_st.chg_en  = 1'b1;
                next_st.phase   = vpc_pkg::VPC_OPEN;
                next_st.win_cnt = 3'h0;
            end else if (st.chg_en) begin
                next_st.vec_sel = avs_req.writedata[`VPC_BIT_VEC_SEL];
                next_st.chg_en  = 1'b0;
                next_st.phase   = vpc_pkg::VPC_HOLD;
            end
            if (st.scan_cnt != 3'h0 &&
                st.scan_val == avs_req.writedata[`VPC_BIT_SCAN_DIS]) begin
                next_st.scan_dis = st.scan_val;
                next_st.scan_cnt = 3'h0;
            end else begin
                next_st.scan_val = avs_req.writedata[`VPC_BIT_SCAN_DIS];
                next_st.scan_cnt = `VPC_WINDOW_CYC;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st <= '{vec_sel: 1'b0, chg_en: 1'b0, pullup_off: 1'b0, scan_dis: 1'b0,
                    phase: vpc_pkg::VPC_IDLE, win_cnt: 3'h0, scan_cnt: 3'h0,
                    scan_val: 1'b0, rd_ack: 1'b0, readdata: `VPC_CTRL_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.readdata;
    assign vec_sel = st.vec_sel;
    assign global_pullup_off = st.pullup_off;
    // vector table base follows select; reset address follows fuse
    assign sect_base = st.vec_sel ? boot_base : `VPC_APP_BASE;
    assign vector_base = sect_base + `VPC_VEC_OFFSET;
    assign last_vector_addr = sect_base + `VPC_LAST_VEC_OFS;
    assign reset_address = fuses.boot_reset_fuse ? boot_base : `VPC_APP_BASE;
    // only an extra mask; processor flags are never touched here
    assign irq_block = (st.phase != vpc_pkg::VPC_IDLE)
                     || (wr_hit && avs_req.writedata[`VPC_BIT_CHG_EN])
                     || (st.vec_sel && fuses.app_side_lock_bit && !exec_in_boot)
                     || (!st.vec_sel && fuses.boot_side_lock_bit && exec_in_boot);
    assign scan_port_active = fuses.scan_enable_fuse && !st.scan_dis;
    // pattern 2'b01 on direction/output asks for a pull-up
    assign pullup_enable = ~pin_direction_bit & pin_output_bit
                         & {PORT_PINS{!st.pullup_off}};
endmodule // vpc_control
`default_nettype wire

// ---- verilog/vpc_map.svh ----
// register map, field positions and timing constants of the vector placement control
`ifndef VPC_MAP_SVH
`define VPC_MAP_SVH
`define VPC_CTRL_ADDR      8'h55
`define VPC_BIT_CHG_EN     0
`define VPC_BIT_VEC_SEL    1
`define VPC_BIT_PULLUP_OFF 4
`define VPC_BIT_SCAN_DIS   7
`define VPC_RW_MASK        8'h93
`define VPC_CTRL_RESET     8'h00
`define VPC_WINDOW_CYC     3'h4
`define VPC_BOOT_8K_BASE   16'hf000
`define VPC_APP_BASE       16'h0000
`define VPC_VEC_OFFSET     16'h0002
`define VPC_LAST_VEC_OFS   16'h008e
`define VPC_BUS_WAIT       1'b0
`endif

// ---- verilog/vpc_pkg.sv ----
// types shared by the vector placement control
package vpc_pkg;
    typedef struct packed {
        logic [7:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } vpc_bus_req_t;
    typedef struct packed {
        logic       boot_reset_fuse;
        logic [1:0] boot_size_fuse;
        logic       app_side_lock_bit;
        logic       boot_side_lock_bit;
        logic       scan_enable_fuse;
    } vpc_fuse_t;
    typedef enum logic [1:0] {VPC_IDLE, VPC_OPEN, VPC_HOLD} vpc_phase_t;
    typedef struct packed {
        logic       vec_sel;
        logic       chg_en;
        logic       pullup_off;
        logic       scan_dis;
        vpc_phase_t phase;
        logic [2:0] win_cnt;
        logic [2:0] scan_cnt;
        logic       scan_val;
        logic       rd_ack;
        logic [7:0] readdata;
    } vpc_state_t;
endpackage

// ---- verilog/vpc_boot_base.sv ----
// boot section base decoder driven by the boot size fuses
`timescale 1ns/1ps
`default_nettype none
`include "vpc_map.svh"
module vpc_boot_base #(
    parameter logic [15:0] BASE_4K = 16'hf800,
    parameter logic [15:0] BASE_2K = 16'hfc00,
    parameter logic [15:0] BASE_1K = 16'hfe00
) (
    input  wire logic [1:0]  boot_size_fuse,
    output logic      [15:0] boot_base
);
    // fuse code 2'b00 selects the largest (8 KByte) section
    always_comb begin
        case (boot_size_fuse)
            2'b00:   boot_base = `VPC_BOOT_8K_BASE;
            2'b01:   boot_base = BASE_4K;
            2'b10:   boot_base = BASE_2K;
            default: boot_base = BASE_1K;
        endcase
    end
endmodule // vpc_boot_base
`default_nettype wire

// ---- dv/vpc_cpu_model.sv ----
// instruction retire model of the cpu core
`timescale 1ns/1ps
`default_nettype none
module vpc_cpu_model (
    input  wire logic ref_clk,
    input  wire logic reset,
    output logic      instr_done
);
    logic [1:0] phase;
    // multi-cycle instructions: one retires every third cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            instr_done <= (phase == 2'h2);
        end
    end
endmodule // vpc_cpu_model
`default_nettype wire

// ---- dv/vpc_control_monitor.sv ----
// assertion checker of the vector placement control
`timescale 1ns/1ps
`default_nettype none
module vpc_control_monitor #(parameter int PORT_PINS = 8) (
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire vpc_pkg::vpc_bus_req_t avs_req,
    input wire logic [7:0]            avs_readdata,
    input wire vpc_pkg::vpc_fuse_t    fuses,
    input wire logic                  exec_in_boot,
    input wire logic [PORT_PINS-1:0]  pin_direction_bit,
    input wire logic [PORT_PINS-1:0]  pin_output_bit,
    input wire logic [PORT_PINS-1:0]  pullup_enable,
    input wire logic                  irq_block,
    input wire logic                  vec_sel,
    input wire logic [15:0]           vector_base,
    input wire logic [15:0]           reset_address,
    input wire logic [15:0]           last_vector_addr,
    input wire logic                  global_pullup_off
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic hit = (avs_req.address == 8'h55);
    wire logic unl = avs_req.write && hit && avs_req.writedata[0];
    wire logic nolock = !fuses.app_side_lock_bit && !fuses.boot_side_lock_bit;
    a_unlock_mask: assert property (unl |-> irq_block) else $error("unlock not masked");
    a_mask_release: assert property (unl && nolock ##1 (!avs_req.write && nolock)[*5]
        |-> !irq_block) else $error("mask held too long");
    a_sel_guard: assert property ($changed(vec_sel) |-> $past(avs_req.write && hit))
        else $error("select moved without write");
    a_flash_base: assert property (!vec_sel |-> vector_base == 16'h0002
        && last_vector_addr == 16'h008e) else $error("flash vectors wrong");
    a_boot_base: assert property (vec_sel && fuses.boot_size_fuse == 2'b00
        |-> vector_base == 16'hf002 && last_vector_addr == 16'hf08e) else $error("boot vectors");
    a_reset_addr: assert property (fuses.boot_size_fuse == 2'b00
        |-> reset_address == (fuses.boot_reset_fuse ? 16'hf000 : 16'h0000)) else $error("rst");
    a_pullup_gate: assert property (pullup_enable == (~pin_direction_bit & pin_output_bit
        & {PORT_PINS{!global_pullup_off}})) else $error("pull-up gate wrong");
    a_lock_block: assert property (vec_sel && fuses.app_side_lock_bit && !exec_in_boot
        || !vec_sel && fuses.boot_side_lock_bit && exec_in_boot |-> irq_block) else $error("lock");
    a_read_zero: assert property (avs_req.read && !hit |=> avs_readdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // vpc_control_monitor
bind vpc_control vpc_control_monitor #(.PORT_PINS(PORT_PINS)) u_mon (.ref_clk(ref_clk),
    .reset(reset), .avs_req(avs_req), .avs_readdata(avs_readdata), .fuses(fuses),
    .exec_in_boot(exec_in_boot), .pin_direction_bit(pin_direction_bit),
    .pin_output_bit(pin_output_bit), .pullup_enable(pullup_enable), .irq_block(irq_block),
    .vec_sel(vec_sel), .vector_base(vector_base), .reset_address(reset_address),
    .last_vector_addr(last_vector_addr), .global_pullup_off(global_pullup_off));
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the vector placement control
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, reset, instr_done, exec_in_boot, irq_block, vec_sel, wait_rq, scan_act, pu_off;
    vpc_pkg::vpc_bus_req_t req;
    vpc_pkg::vpc_fuse_t    fuses;
    logic [7:0]            rdata, dir, out, pull;
    logic [15:0]           vbase, rst_addr, last_vec;
    int                    num_errors = 0, compares = 0;
    vpc_control dut (.ref_clk(ref_clk), .reset(reset), .avs_req(req), .avs_waitrequest(wait_rq),
        .avs_readdata(rdata), .fuses(fuses), .exec_in_boot(exec_in_boot),
        .instr_done(instr_done), .pin_direction_bit(dir), .pin_output_bit(out),
        .pullup_enable(pull), .irq_block(irq_block), .vec_sel(vec_sel), .vector_base(vbase),
        .reset_address(rst_addr), .last_vector_addr(last_vec), .scan_port_active(scan_act),
        .global_pullup_off(pu_off));
    vpc_cpu_model cpu (.ref_clk(ref_clk), .reset(reset), .instr_done(instr_done));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus cycle; read data taken at the edge that sees waitrequest low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        int n;
        logic [7:0] got;
        n = 0;
        req <= '{address: a, read: !w, write: w, writedata: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 20);
        got = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        if (!w) chk(got, e);
        @(posedge ref_clk);
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        reset = 1'b1;
        req = '0;
        fuses = 6'h21;
        exec_in_boot = 1'b0;
        dir = 8'h0f;
        out = 8'hff;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        xfer(1'b0, 8'h55, 8'h00, 8'h00);
        xfer(1'b1, 8'h55, 8'hfe, 8'h00);
        xfer(1'b0, 8'h55, 8'h00, 8'h10);
        chk(pull, 8'h00);
        chk(scan_act, 1'b1);
        xfer(1'b1, 8'h55, 8'h01, 8'h00);
        xfer(1'b1, 8'h55, 8'h02, 8'h00);
        chk({vec_sel, pull, rst_addr}, {1'b1, 8'hf0, 16'hf000});
        chk(vbase, 16'hf002);
        xfer(1'b1, 8'h55, 8'h01, 8'h00);
        repeat (6) @(posedge ref_clk);
        chk(irq_block, 1'b0);
        xfer(1'b1, 8'h55, 8'h00, 8'h00);
        chk(vec_sel, 1'b1);
        xfer(1'b1, 8'h55, 8'h80, 8'h00);
        xfer(1'b1, 8'h55, 8'h80, 8'h00);
        xfer(1'b0, 8'h55, 8'h00, 8'h82);
        chk(scan_act, 1'b0);
        fuses <= 6'h25;
        @(negedge ref_clk);
        chk(irq_block, 1'b1);
        xfer(1'b0, 8'h54, 8'h00, 8'h00);
        // second reset drops the select, then the boot-side lock applies
        reset <= 1'b1;
        fuses <= 6'h23;
        exec_in_boot <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk({vec_sel, irq_block}, 2'b01);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
